/* File: src/pmsl_top.sv */
/*
 Position monitor setup and supervision: units, resolution, display hold with
 dwell, auxiliary LED, move-detection watchdog, upper limit relay.
 Assumes pos_i comes from same-clock transducer logic in thousandths; aux_i and
 linear_i are pins and are synchronised here.
 // How it works
 // - unit bit, 0 inches, 1 millimetres
 // - unit change resets resolution to default
 // - resolution 0 whole to 3 thousandths
 // - hold mode 0 off, 1 energised, 2 released
 // - hold enabled disables watchdog, reuses time-out
 // - display stays frozen for dwell after release
 // - hold freezes display only, limits stay live
 // - aux LED shows hold when enabled
 // - time-out 0 to 99.99 s, zero disables
 // - aux assertion starts movement watch timing
 // - no movement: relays drop, fault shown
 // - fault latched until explicit clear
 // - upper relay and LED at limit reached
 // - upper limit 0 to 999.999, reset max
 // - setup writes only in program mode
 // - relay polarity bit inverts relay sense
*/
`timescale 1ns/10ps
module pmsl_top #(
  parameter int TICK_CYCLES = pmsl_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [pmsl_pkg::POS_W-1:0] pos_i,
  input wire logic aux_i,
  input wire logic linear_i,
  output logic [pmsl_pkg::POS_W-1:0] disp_pos_o,
  output logic [1:0] disp_res_o,
  output logic disp_mm_o,
  output logic disp_err_o,
  output pmsl_pkg::pmsl_ind_type ind_o,
  output logic irq_o
);
  import pmsl_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ***************
  // 10 ms tick
  // ***************
  logic [TW-1:0] tdiv_reg;
  logic tick;
  assign tick = (tdiv_reg == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tdiv_reg <= '0;
    else
      tdiv_reg <= tdiv_reg + 1'b1;
  end

  // ***************
  // pin synchronisers
  // ***************
  logic aux_s1_reg, aux_s2_reg, aux_d_reg, lin_s1_reg, lin_s2_reg;
  logic aux_rise;
  assign aux_rise = aux_s2_reg & ~aux_d_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aux_s1_reg <= 1'b0;
      aux_s2_reg <= 1'b0;
      aux_d_reg <= 1'b0;
      lin_s1_reg <= 1'b0;
      lin_s2_reg <= 1'b0;
    end
    else
    begin
      aux_s1_reg <= aux_i;
      aux_s2_reg <= aux_s1_reg;
      aux_d_reg <= aux_s2_reg;
      lin_s1_reg <= linear_i;
      lin_s2_reg <= lin_s1_reg;
    end
  end

  // ***************
  // bus decode
  // ***************
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  logic ack_reg;
  logic [31:0] dat_reg, rd_v, wv;
  logic [7:0] adr;
  logic acc, wr, prog_wr, fclr;
  assign adr = {wb_adr_i[7:2], 2'h0};
  assign acc = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = acc & wb_we_i;
  assign wv = wb_merge(rd_v, wb_dat_i, wb_sel_i);

  // ***************
  // setup registers
  // ***************
  logic prog_mode_reg, unit_reg, aux_en_reg, pol_reg;
  logic [1:0] res_reg, hold_mode_reg;
  logic [TMO_W-1:0] tmo_reg;
  logic [LIM_W-1:0] uplim_reg;
  logic [IRQ_W-1:0] irq_st_reg, irq_en_reg, irq_ev;
  assign prog_wr = wr & prog_mode_reg;
  assign fclr = wr & (adr == REG_FCLR) & wv[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prog_mode_reg <= 1'b0;
    else if (wr && adr == REG_PROG)
      prog_mode_reg <= wv[0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unit_reg <= 1'b0;
      res_reg <= RES_IN;
    end
    else if (prog_wr && adr == REG_UNIT)
    begin
      unit_reg <= wv[0];
      if (wv[0] != unit_reg)
        res_reg <= wv[0] ? RES_MM : RES_IN;
    end
    else if (prog_wr && adr == REG_RES)
      res_reg <= wv[1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_mode_reg <= HOLD_OFF;
      aux_en_reg <= 1'b0;
      pol_reg <= 1'b0;
    end
    else if (prog_wr)
    begin
      if (adr == REG_HOLD && wv[1:0] <= HOLD_ON_LO)
        hold_mode_reg <= wv[1:0];
      if (adr == REG_AUXLED)
        aux_en_reg <= wv[0];
      if (adr == REG_POL)
        pol_reg <= wv[0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmo_reg <= TMO_RST;
      uplim_reg <= LIM_RST;
    end
    else if (prog_wr)
    begin
      if (adr == REG_TMO && wv <= 32'(TMO_MAX))
        tmo_reg <= wv[TMO_W-1:0];
      if (adr == REG_UPLIM && wv <= 32'(LIM_MAX))
        uplim_reg <= wv[LIM_W-1:0];
    end
  end

  a_prog_guard: assert property (wr && !prog_mode_reg && adr == REG_UPLIM |=> $stable(uplim_reg))
    else $error("limit changed outside program mode");
  a_unit_res: assert property (prog_wr && adr == REG_UNIT && wv[0] != unit_reg |=> res_reg == (unit_reg ? RES_MM : RES_IN))
    else $error("resolution not defaulted on unit change");
  a_tmo_range: assert property (tmo_reg <= TMO_MAX)
    else $error("time-out above range");

  // ***************
  // move-detection watchdog
  // ***************
  pmsl_wd_type wd_state;
  logic [TMO_W-1:0] wd_cnt_reg;
  logic [POS_W-1:0] cap_pos_reg;
  logic fault;
  assign fault = (wd_state == WD_FAULT);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wd_state <= WD_IDLE;
      wd_cnt_reg <= '0;
      cap_pos_reg <= '0;
    end
    else
    begin
      case (wd_state)
        WD_IDLE:
          if (aux_rise && hold_mode_reg == HOLD_OFF && tmo_reg != '0)
          begin
            wd_state <= WD_WATCH;
            wd_cnt_reg <= '0;
            cap_pos_reg <= pos_i;
          end
        WD_WATCH:
          if (hold_mode_reg != HOLD_OFF || tmo_reg == '0)
            wd_state <= WD_IDLE;
          else if (pos_i != cap_pos_reg)
            wd_state <= WD_IDLE;
          else if (tick)
          begin
            if (wd_cnt_reg + 1'b1 >= tmo_reg)
              wd_state <= WD_FAULT;
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
          end
        WD_FAULT:
          if (fclr)
            wd_state <= WD_IDLE;
        default:
          wd_state <= WD_IDLE;
      endcase
    end
  end

  sequence s_wdog_arm;
    wd_state == WD_IDLE && aux_rise && hold_mode_reg == HOLD_OFF && tmo_reg != '0;
  endsequence
  sequence s_fault_held;
    fault && !fclr;
  endsequence
  a_wdog_arm: assert property (s_wdog_arm |=> wd_state == WD_WATCH)
    else $error("watchdog did not arm on aux rise");
  a_fault_latch: assert property (s_fault_held |=> fault)
    else $error("fault dropped without clear");
  a_hold_wdog: assert property (hold_mode_reg != HOLD_OFF |=> wd_state != WD_WATCH)
    else $error("watchdog running with hold enabled");

  // ***************
  // display hold and dwell
  // ***************
  logic hold_cond, hold_cond_d_reg, dwell_run_reg, hold_active, hold_act_d_reg;
  logic [TMO_W-1:0] dwell_reg;
  logic [POS_W-1:0] disp_reg;
  assign hold_cond = (hold_mode_reg == HOLD_ON_HI && aux_s2_reg) ||
                     (hold_mode_reg == HOLD_ON_LO && !aux_s2_reg);
  assign hold_active = hold_cond || dwell_run_reg ||
                       (hold_cond_d_reg && tmo_reg != '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_cond_d_reg <= 1'b0;
      dwell_run_reg <= 1'b0;
      dwell_reg <= '0;
    end
    else
    begin
      hold_cond_d_reg <= hold_cond;
      if (hold_cond)
        dwell_run_reg <= 1'b0;
      else if (hold_cond_d_reg)
      begin
        dwell_run_reg <= (tmo_reg != '0);
        dwell_reg <= tmo_reg;
      end
      else if (dwell_run_reg && tick)
      begin
        if (dwell_reg <= 1)
          dwell_run_reg <= 1'b0;
        dwell_reg <= dwell_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      disp_reg <= '0;
    else if (!hold_active)
      disp_reg <= pos_i;
  end

  a_hold_freeze: assert property (hold_active |=> $stable(disp_pos_o))
    else $error("display moved during hold");

  // ***************
  // limit and indicators
  // ***************
  logic upper_hit, upper_d_reg, fault_d_reg;
  pmsl_ind_type ind_reg;
  assign upper_hit = (pos_i >= uplim_reg);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ind_reg <= '0;
      upper_d_reg <= 1'b0;
      fault_d_reg <= 1'b0;
      hold_act_d_reg <= 1'b0;
    end
    else
    begin
      ind_reg.relay_up <= ~((upper_hit | fault) ^ pol_reg);
      ind_reg.relay_lo <= ~(fault ^ pol_reg);
      ind_reg.fault_ok <= ~fault;
      ind_reg.led_up <= upper_hit;
      ind_reg.led_fault <= fault;
      ind_reg.led_aux <= aux_en_reg & hold_active;
      upper_d_reg <= upper_hit;
      fault_d_reg <= fault;
      hold_act_d_reg <= hold_active;
    end
  end

  a_fault_outs: assert property (fault |=> !ind_o.fault_ok && ind_o.led_fault && disp_err_o)
    else $error("fault outputs not shown");
  a_aux_led: assert property (!aux_en_reg |=> !ind_o.led_aux)
    else $error("aux led lit while disabled");
  a_upper_relay: assert property (upper_hit && !fault |=> ind_o.led_up && ind_o.relay_up == $past(pol_reg))
    else $error("upper limit not actuated");

  // ***************
  // interrupts
  // ***************
  assign irq_ev[IRQ_FAULT] = fault & ~fault_d_reg;
  assign irq_ev[IRQ_UPPER] = upper_hit & ~upper_d_reg;
  assign irq_ev[IRQ_HOLD] = hold_active & ~hold_act_d_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_st_reg <= '0;
      irq_en_reg <= '0;
    end
    else
    begin
      if (wr && adr == REG_IRQ_CLR)
        irq_st_reg <= (irq_st_reg & ~wv[IRQ_W-1:0]) | irq_ev;
      else
        irq_st_reg <= irq_st_reg | irq_ev;
      if (wr && adr == REG_IRQ_EN)
        irq_en_reg <= wv[IRQ_W-1:0];
    end
  end

  // ***************
  // read mux and bus answer
  // ***************
  always_comb
  begin
    rd_v = '0;
    case (adr)
      REG_UNIT: rd_v[0] = unit_reg;
      REG_RES: rd_v[1:0] = res_reg;
      REG_HOLD: rd_v[1:0] = hold_mode_reg;
      REG_AUXLED: rd_v[0] = aux_en_reg;
      REG_TMO: rd_v[TMO_W-1:0] = tmo_reg;
      REG_UPLIM: rd_v[LIM_W-1:0] = uplim_reg;
      REG_POL: rd_v[0] = pol_reg;
      REG_PROG: rd_v[0] = prog_mode_reg;
      REG_STAT:
      begin
        rd_v[ST_PROG] = prog_mode_reg;
        rd_v[ST_FAULT] = fault;
        rd_v[ST_UPPER] = upper_hit;
        rd_v[ST_HOLD] = hold_active;
        rd_v[ST_AUX] = aux_s2_reg;
      end
      REG_DISP: rd_v[POS_W-1:0] = disp_reg;
      REG_IRQ_ST: rd_v[IRQ_W-1:0] = irq_st_reg;
      REG_IRQ_EN: rd_v[IRQ_W-1:0] = irq_en_reg;
      default: rd_v = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= acc;
      if (acc && !wb_we_i)
        dat_reg <= rd_v;
    end
  end

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign disp_pos_o = disp_reg;
  assign disp_res_o = res_reg;
  assign disp_mm_o = unit_reg & lin_s2_reg;
  assign disp_err_o = ind_reg.led_fault;
  assign ind_o = ind_reg;
  assign irq_o = |(irq_st_reg & irq_en_reg);
endmodule

/* File: src/pmsl_pkg.sv */
/*
 Constants, register map and carrier types of the position monitor setup block.
 Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package pmsl_pkg;
  // ***************
  // timing
  // ***************
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  // ***************
  // widths and limits
  // ***************
  localparam int TMO_W = 14;
  localparam int LIM_W = 20;
  localparam int POS_W = LIM_W;
  localparam logic [TMO_W-1:0] TMO_MAX = 14'h270f;
  localparam logic [TMO_W-1:0] TMO_RST = 14'h01f4;
  localparam logic [LIM_W-1:0] LIM_MAX = 20'hf423f;
  localparam logic [LIM_W-1:0] LIM_RST = 20'hf423f;

  // ***************
  // register byte offsets
  // ***************
  localparam logic [7:0] REG_UNIT = 8'h00;
  localparam logic [7:0] REG_RES = 8'h04;
  localparam logic [7:0] REG_HOLD = 8'h08;
  localparam logic [7:0] REG_AUXLED = 8'h0c;
  localparam logic [7:0] REG_TMO = 8'h10;
  localparam logic [7:0] REG_UPLIM = 8'h14;
  localparam logic [7:0] REG_POL = 8'h18;
  localparam logic [7:0] REG_PROG = 8'h1c;
  localparam logic [7:0] REG_FCLR = 8'h20;
  localparam logic [7:0] REG_STAT = 8'h24;
  localparam logic [7:0] REG_DISP = 8'h28;
  localparam logic [7:0] REG_IRQ_ST = 8'h2c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h30;
  localparam logic [7:0] REG_IRQ_EN = 8'h34;

  // ***************
  // field values
  // ***************
  localparam logic [1:0] RES_WHOLE = 2'h0;
  localparam logic [1:0] RES_MM = 2'h2;
  localparam logic [1:0] RES_IN = 2'h3;
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_ON_HI = 2'h1;
  localparam logic [1:0] HOLD_ON_LO = 2'h2;
  localparam int ST_PROG = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_UPPER = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_AUX = 4;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_UPPER = 1;
  localparam int IRQ_HOLD = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {WD_IDLE, WD_WATCH, WD_FAULT} pmsl_wd_type;

  typedef struct packed {
    logic relay_up;
    logic relay_lo;
    logic fault_ok;
    logic led_up;
    logic led_fault;
    logic led_aux;
  } pmsl_ind_type;
endpackage

/* File: tb/pmsl_drive_model.sv */
/*
 Model of the machine drive and position transducer on the far side.
 Assumes the bench commands it at rising clock edges.
*/
`timescale 1ns/10ps
module pmsl_drive_model (
  input wire logic clk_i,
  input wire logic drive_on_i,
  input wire logic [pmsl_pkg::POS_W-1:0] target_i,
  output logic aux_o,
  output logic [pmsl_pkg::POS_W-1:0] pos_o
);
  import pmsl_pkg::*;
  // aux energised while drive power is applied
  always_ff @(posedge clk_i)
  begin
    aux_o <= drive_on_i;
    pos_o <= target_i;
  end
endmodule

/* File: tb/tb_top.sv */
/*
 Self-checking bench of the position monitor setup block.
 Assumes the drive model and a 10-cycle tick.
*/
`timescale 1ns/10ps
module tb_top;
  import pmsl_pkg::*;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic lin;
  logic drv;
  logic [POS_W-1:0] tgt;
  logic aux;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] dpos;
  logic [1:0] dres;
  logic dmm;
  logic derr;
  pmsl_ind_type ind;
  logic irq;
  int n_mismatch;
  int comparisons;
  pmsl_top #(.TICK_CYCLES(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pos_i(pos), .aux_i(aux), .linear_i(lin),
    .disp_pos_o(dpos), .disp_res_o(dres), .disp_mm_o(dmm), .disp_err_o(derr),
    .ind_o(ind), .irq_o(irq));
  pmsl_drive_model drive (.clk_i(clk_i), .drive_on_i(drv), .target_i(tgt),
    .aux_o(aux), .pos_o(pos));
  always #4 clk_i = ~clk_i;
  // ***************
  // helpers
  // ***************
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk_i);
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      conclude;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // ***************
  // scenarios
  // ***************
  task t_defaults;
    rd(REG_UNIT, 32'h0);
    rd(REG_RES, 32'h3);
    rd(REG_HOLD, 32'h0);
    rd(REG_AUXLED, 32'h0);
    rd(REG_TMO, 32'h1f4);
    rd(REG_UPLIM, 32'hf423f);
    rd(REG_POL, 32'h0);
    chk(32'(ind), 32'h38);
  endtask
  task t_prog;
    int i;
    wr(REG_UNIT, 32'h1);
    rd(REG_UNIT, 32'h0);
    wr(REG_PROG, 32'h1);
    wr(REG_UNIT, 32'h1);
    rd(REG_RES, 32'h2);
    chk(32'(dmm), 32'h1);
    chk(32'(dres), 32'h2);
    lin <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(dmm), 32'h0);
    lin <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      wr(REG_RES, 32'(i));
      rd(REG_RES, 32'(i));
    end
    wr(REG_UNIT, 32'h0);
    rd(REG_RES, 32'h3);
    wr(REG_TMO, 32'h2710);
    rd(REG_TMO, 32'h1f4);
    wr(REG_UPLIM, 32'hf4240);
    rd(REG_UPLIM, 32'hf423f);
    rd(8'h3c, 32'h0);
  endtask
  task t_limit;
    tgt <= 20'd999;
    wr(REG_UPLIM, 32'd1000);
    repeat (4) @(posedge clk_i);
    chk(32'(ind.led_up), 32'h0);
    tgt <= 20'd1000;
    repeat (4) @(posedge clk_i);
    chk(32'({ind.relay_up, ind.led_up}), 32'h1);
    wr(REG_POL, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(ind.relay_up), 32'h1);
    wr(REG_POL, 32'h0);
    rd(REG_IRQ_ST, 32'h2);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_EN, 32'h2);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_CLR, 32'h2);
    chk(32'(irq), 32'h0);
    wr(REG_UPLIM, 32'hf423f);
  endtask
  task t_fault;
    int n;
    wr(REG_TMO, 32'h5);
    tgt <= 20'd10;
    repeat (3) @(posedge clk_i);
    drv <= 1'b1;
    for (n = 0; n < 200 && derr !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 200)
    begin
      n_mismatch++;
      conclude;
    end
    chk(32'(n >= 40), 32'h1);
    chk(32'(ind), 32'h02);
    drv <= 1'b0;
    tgt <= 20'd50;
    repeat (60) @(posedge clk_i);
    chk(32'(derr), 32'h1);
    wr(REG_FCLR, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(ind), 32'h38);
    drv <= 1'b1;
    repeat (20) @(posedge clk_i);
    tgt <= 20'd60;
    repeat (150) @(posedge clk_i);
    chk(32'(derr), 32'h0);
    drv <= 1'b0;
    wr(REG_TMO, 32'h0);
    drv <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk(32'(derr), 32'h0);
    drv <= 1'b0;
  endtask
  task t_hold;
    wr(REG_TMO, 32'h5);
    wr(REG_HOLD, 32'h1);
    wr(REG_AUXLED, 32'h1);
    wr(REG_UPLIM, 32'd150);
    tgt <= 20'd100;
    repeat (5) @(posedge clk_i);
    drv <= 1'b1;
    repeat (8) @(posedge clk_i);
    tgt <= 20'd200;
    repeat (4) @(posedge clk_i);
    chk(32'(dpos), 32'd100);
    chk(32'({ind.led_up, ind.led_aux}), 32'h3);
    drv <= 1'b0;
    repeat (25) @(posedge clk_i);
    chk(32'(dpos), 32'd100);
    repeat (80) @(posedge clk_i);
    chk(32'(dpos), 32'd200);
    wr(REG_HOLD, 32'h2);
    tgt <= 20'd300;
    repeat (4) @(posedge clk_i);
    chk(32'(dpos), 32'd200);
    drv <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk(32'(dpos), 32'd300);
    chk(32'(derr), 32'h0);
    wr(REG_AUXLED, 32'h0);
    drv <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(ind.led_aux), 32'h0);
  endtask
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    lin = 1'b1;
    drv = 1'b0;
    tgt = 20'h0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults;
    t_prog;
    t_limit;
    t_fault;
    t_hold;
    conclude;
  end
endmodule
